// [rtl/bcs_charge_seq.sv]
/*
 * Tick-scheduled charge sequencer with running-average filter, delta-peak
 * termination, charge watchdog and top-up pulses.
 * Assumes an external current source enabled by charge_en and a ramp
 * comparator on cmp_in; indicator outputs drive lamps directly.
 */
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Timer reloads all-ones, one tick per 71 ms
// - Tick counter counts ticks; fourteen make a second
// - Step at tick 0, lamps at 7, wrap 14
// - Reset puts sequencer in fault state
// - Fault with in-range voltage moves to initializing
// - Out-of-range voltage forces fault from any state
// - Initializing primes filter and variables, no decisions
// - After init seconds, move to charging
// - Watchdog bounds total charging time
// - 1% drop below peak or watchdog ends charge
// - Threshold relative to peak, no cell count
// - Done state pulses current one second per interval
// - Decisions use running-average filtered voltage
// - Current source off while measuring voltage
module bcs_charge_seq
   import bcs_pkg::*;
#(
   parameter int STEP_DIV = STEP_CYCLES,
   parameter logic [15:0] RELOAD = TIMER_RELOAD,
   parameter logic [15:0] INIT_SEC = INIT_SECONDS,
   parameter logic [15:0] WATCHDOG_SEC = WATCHDOG_SECONDS,
   parameter logic [15:0] TOPUP_SEC = TOPUP_SECONDS
)
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmp_in,
   output logic charge_en,
   output logic ramp_clear,
   output logic led_fault,
   output logic led_charge,
   output logic led_done,
   output bcs_pkg::bcs_state_t seq_state
);
   import bcs_pkg::*;

   localparam int AVG_N = 1 << AVG_DEPTH_LOG2;

   if (STEP_DIV < 1 || STEP_DIV > 255 || RELOAD == 16'h0000 || INIT_SEC == 16'h0000 ||
       WATCHDOG_SEC == 16'h0000 || TOPUP_SEC == 16'h0000)
   begin : g_bad_param
      $error("bcs_charge_seq: unsupported parameter value");
   end

   typedef struct packed {
      logic [7:0] pre;
      logic [15:0] tmr;
      logic [3:0] tick;
      logic [15:0] phase_sec;
      bcs_state_t st;
      logic [AVG_N-1:0][15:0] hist;
      logic [15:0] avg;
      logic [15:0] valley;
      logic pulse;
      logic [2:0] leds;
      logic start;
   } bcs_seq_st_t;

   bcs_seq_st_t s_q, s_d;
   bcs_meas_if mif ();

   logic step_en;
   logic tick_ev;
   logic [3:0] tick_nx;
   logic sec_ev;
   logic [15:0] sum_lo;
   logic [AVG_DEPTH_LOG2+15:0] sum;
   logic [15:0] avg_new;
   logic in_range;
   logic dropped;

   // ****************************************
   // Period converter
   // ****************************************
   bcs_period_meas u_meas (
      .mclk(mclk),
      .rst(rst),
      .cmp(cmp_in),
      .m(mif.meas)
   );

   assign step_en = (s_q.pre == 8'(STEP_DIV - 1));
   assign mif.step_en = step_en;
   assign mif.start = s_q.start;

   // ****************************************
   // Tick timer and scheduler
   // ****************************************
   assign tick_ev = step_en && (s_q.tmr == 16'h0000);
   assign tick_nx = s_q.tick + 4'h1;
   assign sec_ev = tick_ev && (tick_nx == TICKS_PER_SECOND);

   // ****************************************
   // Running average of the newest samples
   // ****************************************
   always_comb
   begin
      sum = '0;
      sum_lo = 16'h0000;
      sum = (AVG_DEPTH_LOG2 + 16)'(mif.period);
      for (int i = 0; i < AVG_N - 1; i++)
         sum = sum + (AVG_DEPTH_LOG2 + 16)'(s_q.hist[i]);
      sum_lo = sum[AVG_DEPTH_LOG2 +: 16];
   end

   assign avg_new = sum_lo;
   assign in_range = (avg_new >= MIN_BATT_PERIOD) && (avg_new <= MAX_BATT_PERIOD);
   // Longer period means lower voltage; compare scaled, no division needed
   assign dropped = (24'(avg_new) * 24'(DROP_MUL_NOW)) >= (24'(s_q.valley) * 24'(DROP_MUL_VALLEY));

   // ****************************************
   // Sequencer
   // ****************************************
   always_comb
   begin
      s_d = s_q;
      s_d.start = 1'b0;
      s_d.pre = step_en ? 8'h00 : s_q.pre + 8'h01;
      if (step_en)
         s_d.tmr = (s_q.tmr == 16'h0000) ? RELOAD : s_q.tmr - 16'h0001;
      if (tick_ev)
      begin
         s_d.tick = sec_ev ? 4'h0 : tick_nx;
         if (sec_ev)
            s_d.start = 1'b1;
         if (tick_nx == LED_TICK)
            s_d.leds = {s_q.st == ST_DONE, s_q.st == ST_CHARGE || s_q.st == ST_INIT,
                        s_q.st == ST_FAULT};
      end
      if (sec_ev)
      begin
         s_d.phase_sec = s_q.phase_sec + 16'h0001;
         if (s_q.st == ST_DONE)
         begin
            if (s_q.pulse && s_q.phase_sec + 16'h0001 >= PULSE_SECONDS)
            begin
               s_d.pulse = 1'b0;
               s_d.phase_sec = 16'h0000;
            end
            else if (!s_q.pulse && s_q.phase_sec + 16'h0001 >= TOPUP_SEC)
            begin
               s_d.pulse = 1'b1;
               s_d.phase_sec = 16'h0000;
            end
         end
      end
      // Sequencer step runs once the tick-0 measurement completes
      if (mif.done)
      begin
         s_d.hist = {s_q.hist[AVG_N-2:0], mif.period};
         s_d.avg = avg_new;
         if (!in_range)
         begin
            s_d.st = ST_FAULT;
            s_d.pulse = 1'b0;
         end
         else
         begin
            case (s_q.st)
               ST_FAULT:
               begin
                  s_d.st = ST_INIT;
                  s_d.phase_sec = 16'h0000;
               end
               ST_INIT:
               begin
                  s_d.valley = avg_new;
                  if (s_q.phase_sec >= INIT_SEC)
                  begin
                     s_d.st = ST_CHARGE;
                     s_d.phase_sec = 16'h0000;
                  end
               end
               ST_CHARGE:
               begin
                  if (avg_new < s_q.valley)
                     s_d.valley = avg_new;
                  if (dropped || s_q.phase_sec >= WATCHDOG_SEC)
                  begin
                     s_d.st = ST_DONE;
                     s_d.phase_sec = 16'h0000;
                     s_d.pulse = 1'b0;
                  end
               end
               ST_DONE:
                  s_d.st = ST_DONE;
               default:
                  s_d.st = ST_FAULT;
            endcase
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.tmr <= RELOAD;
         s_q.st <= ST_FAULT;
         s_q.leds <= 3'h1;
      end
      else
         s_q <= s_d;
   end

   // ****************************************
   // Outputs
   // ****************************************
   // Switching noise would corrupt the ramp, so the source idles from the request on
   assign charge_en = ((s_q.st == ST_CHARGE) || (s_q.st == ST_DONE && s_q.pulse)) && !mif.busy && !s_q.start;
   assign ramp_clear = mif.ramp_clear;
   assign led_fault = s_q.leds[0];
   assign led_charge = s_q.leds[1];
   assign led_done = s_q.leds[2];
   assign seq_state = s_q.st;

   // ****************************************
   // Assertions
   // ****************************************
   property p_tick_reload;
      @(posedge mclk) disable iff (rst) tick_ev |=> (s_q.tmr == RELOAD);
   endproperty
   a_tick_reload: assert property (p_tick_reload) else $error("timer not reloaded");

   property p_tick_range;
      @(posedge mclk) disable iff (rst) s_q.tick < TICKS_PER_SECOND;
   endproperty
   a_tick_range: assert property (p_tick_range) else $error("tick count past wrap");

   property p_step_start;
      @(posedge mclk) disable iff (rst) sec_ev |=> s_q.start ##1 (s_q.tick == SEQ_TICK && mif.busy);
   endproperty
   a_step_start: assert property (p_step_start) else $error("step not started at tick 0");

   property p_fault_exit;
      @(posedge mclk) disable iff (rst) (mif.done && in_range && s_q.st == ST_FAULT) |=> s_q.st == ST_INIT;
   endproperty
   a_fault_exit: assert property (p_fault_exit) else $error("fault not left");

   property p_out_of_range;
      @(posedge mclk) disable iff (rst) (mif.done && !in_range) |=> (s_q.st == ST_FAULT && !charge_en);
   endproperty
   a_out_of_range: assert property (p_out_of_range) else $error("range fault missed");

   property p_init_hold;
      @(posedge mclk) disable iff (rst)
         (s_q.st == ST_INIT && s_q.phase_sec < INIT_SEC) |=> s_q.st inside {ST_INIT, ST_FAULT};
   endproperty
   a_init_hold: assert property (p_init_hold) else $error("early init exit");

   property p_watchdog;
      @(posedge mclk) disable iff (rst)
         (mif.done && in_range && s_q.st == ST_CHARGE && s_q.phase_sec >= WATCHDOG_SEC) |=> s_q.st == ST_DONE;
   endproperty
   a_watchdog: assert property (p_watchdog) else $error("watchdog ignored");

   property p_no_charge_measuring;
      @(posedge mclk) disable iff (rst) mif.busy |-> !charge_en;
   endproperty
   a_no_charge_measuring: assert property (p_no_charge_measuring) else $error("source on while measuring");

   property p_pulse_restart;
      @(posedge mclk) disable iff (rst) ($fell(s_q.pulse) && s_q.st == ST_DONE) |-> s_q.phase_sec == 16'h0000;
   endproperty
   a_pulse_restart: assert property (p_pulse_restart) else $error("interval not restarted");

   property p_led_slot;
      @(posedge mclk) disable iff (rst) !$stable(s_q.leds) |-> $past(tick_ev) && s_q.tick == LED_TICK;
   endproperty
   a_led_slot: assert property (p_led_slot) else $error("lamps changed off slot");

   property p_reset_state;
      @(posedge mclk) rst |=> (s_q.st == ST_FAULT && s_q.leds == 3'h1 && s_q.tmr == RELOAD);
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

   property p_pulse_rise;
      @(posedge mclk) disable iff (rst) $rose(s_q.pulse) |-> (s_q.st == ST_DONE && s_q.tick == SEQ_TICK);
   endproperty
   a_pulse_rise: assert property (p_pulse_rise) else $error("top-up pulse off its second");

   property p_init_valley;
      @(posedge mclk) disable iff (rst)
         (mif.done && in_range && s_q.st == ST_INIT) |=> s_q.valley == $past(avg_new);
   endproperty
   a_init_valley: assert property (p_init_valley) else $error("valley not primed");

   property p_drop_end;
      @(posedge mclk) disable iff (rst)
         (mif.done && in_range && s_q.st == ST_CHARGE && dropped) |=> s_q.st == ST_DONE;
   endproperty
   a_drop_end: assert property (p_drop_end) else $error("voltage drop ignored");
endmodule // bcs_charge_seq
`default_nettype wire

// [rtl/bcs_meas_if.sv]
/*
 * Carrier between the sequencer and its period converter.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface bcs_meas_if;
   logic step_en;
   logic start;
   logic busy;
   logic done;
   logic ramp_clear;
   logic [15:0] period;
   modport ctl (output step_en, output start, input busy, input done, input ramp_clear, input period);
   modport meas (input step_en, input start, output busy, output done, output ramp_clear, output period);
endinterface
`default_nettype wire

// [rtl/bcs_period_meas.sv]
/*
 * Single-slope converter control: clears the ramp capacitor, then counts
 * timer steps until the comparator trips. Assumes cmp is an asynchronous pin.
 */
`timescale 1ns/100ps
`default_nettype none
module bcs_period_meas
   import bcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic cmp,
   bcs_meas_if.meas m
);
   typedef enum logic [1:0] {M_IDLE, M_CLEAR, M_RAMP} bcs_mstate_t;
   typedef struct packed {
      logic [1:0] sync;
      bcs_mstate_t st;
      logic [15:0] cnt;
      logic done;
      logic clear;
      logic [15:0] period;
   } bcs_meas_st_t;

   bcs_meas_st_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.sync = {s_q.sync[0], cmp};
      s_d.done = 1'b0;
      case (s_q.st)
         M_IDLE:
         begin
            if (m.start)
            begin
               s_d.st = M_CLEAR;
               s_d.cnt = 16'h0000;
               s_d.clear = 1'b1;
            end
         end
         M_CLEAR:
         begin
            if (m.step_en)
            begin
               if (s_q.cnt == DISCHARGE_STEPS - 16'h0001)
               begin
                  s_d.st = M_RAMP;
                  s_d.cnt = 16'h0000;
                  s_d.clear = 1'b0;
               end
               else
                  s_d.cnt = s_q.cnt + 16'h0001;
            end
         end
         M_RAMP:
         begin
            // A stuck-low comparator ends as an out-of-range period
            if (s_q.sync[1] || s_q.cnt > MAX_BATT_PERIOD)
            begin
               s_d.st = M_IDLE;
               s_d.done = 1'b1;
               s_d.period = s_q.cnt;
            end
            else if (m.step_en)
               s_d.cnt = s_q.cnt + 16'h0001;
         end
         default:
            s_d.st = M_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         s_q <= '0;
         s_q.st <= M_IDLE;
      end
      else
         s_q <= s_d;
   end

   assign m.busy = (s_q.st != M_IDLE);
   assign m.done = s_q.done;
   assign m.period = s_q.period;
   assign m.ramp_clear = s_q.clear;
endmodule // bcs_period_meas
`default_nettype wire

// [rtl/bcs_pkg.sv]
/*
 * Constants, timing figures and types shared by the battery charge sequencer.
 * Assumes a 20 MHz system clock; the battery period figures are in timer-step units.
 */
package bcs_pkg;

   // ****************************************
   // Clock and tick timer
   // ****************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam logic [15:0] TIMER_RELOAD = 16'hffff;
   localparam int TICK_PERIOD_MS = 71;
   // One timer step; the longest period rounds down to whole clocks
   localparam int STEP_CYCLES = (TICK_PERIOD_MS * 1000000) / ((int'(TIMER_RELOAD) + 1) * CLK_PERIOD_NS);
   localparam logic [3:0] TICKS_PER_SECOND = 4'he;
   localparam logic [3:0] SEQ_TICK = 4'h0;
   localparam logic [3:0] LED_TICK = 4'h7;

   // ****************************************
   // Voltage-to-period converter
   // ****************************************
   localparam logic [15:0] MIN_BATT_PERIOD = 16'h01ae;
   localparam logic [15:0] MAX_BATT_PERIOD = 16'h159a;
   localparam logic [15:0] DISCHARGE_STEPS = 16'h0010;
   localparam int AVG_DEPTH_LOG2 = 3;

   // ****************************************
   // Sequencer timing, in seconds
   // ****************************************
   localparam logic [15:0] INIT_SECONDS = 16'h0014;
   localparam logic [15:0] WATCHDOG_SECONDS = 16'h0a98;
   localparam logic [15:0] TOPUP_SECONDS = 16'h01f4;
   localparam logic [15:0] PULSE_SECONDS = 16'h0001;

   // Voltage 1% below peak means period at least 100/99 of the valley
   localparam logic [7:0] DROP_MUL_NOW = 8'h63;
   localparam logic [7:0] DROP_MUL_VALLEY = 8'h64;

   typedef enum logic [1:0] {ST_FAULT, ST_INIT, ST_CHARGE, ST_DONE} bcs_state_t;

endpackage

// [testbench/bcs_batt_model.sv]
/*
 * Battery pack model: the ramp comparator seen by the sequencer.
 * Assumes one converter step per mclk; the bench sets the period.
 */
`timescale 1ns/100ps
`default_nettype none
module bcs_batt_model
(
   input wire logic mclk,
   input wire logic ramp_clear,
   input wire logic [15:0] period,
   output var logic cmp_out
);
   logic [15:0] cnt_q;
   initial cmp_out = 1'b0;
   initial cnt_q = 16'h0000;
   // Capacitor held empty while cleared, trips after period steps
   always @(negedge mclk)
   begin
      if (ramp_clear)
      begin
         cnt_q <= 16'h0000;
         cmp_out <= 1'b0;
      end
      else
      begin
         if (cnt_q != 16'hffff)
            cnt_q <= cnt_q + 16'h0001;
         cmp_out <= (cnt_q >= period);
      end
   end
endmodule // bcs_batt_model
`default_nettype wire

// [testbench/testbench.sv]
/*
 * Self-checking bench for the charge sequencer with shortened timing.
 * Assumes the battery model above; one second is 14 ticks of 81 steps.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import bcs_pkg::*;
   localparam int SEC = 14 * 81;
   localparam int INIT_S = 9;
   localparam int WD_S = 10;
   localparam int TOP_S = 3;
   localparam int LIMIT = 95000;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] batt_period = 16'h0320;
   logic cmp_in, charge_en, ramp_clear, led_fault, led_charge, led_done;
   bcs_state_t seq_state;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   int n, len;

   always #25 mclk = ~mclk;

   bcs_charge_seq #(.STEP_DIV(1), .RELOAD(16'h0050), .INIT_SEC(16'h0009), .WATCHDOG_SEC(16'h000a),
      .TOPUP_SEC(16'h0003)) u_bcs_charge_seq (.mclk(mclk), .rst(rst), .cmp_in(cmp_in), .charge_en(charge_en),
      .ramp_clear(ramp_clear), .led_fault(led_fault), .led_charge(led_charge), .led_done(led_done),
      .seq_state(seq_state));
   bcs_batt_model u_bcs_batt_model (.mclk(mclk), .ramp_clear(ramp_clear), .period(batt_period), .cmp_out(cmp_in));

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic check(input logic ok, input string msg);
      checked++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   function automatic logic pick(input int w);
      return (w == 0) ? ramp_clear : charge_en;
   endfunction

   // Counts falling edges until the chosen output reaches lvl
   task automatic wait_for(input int w, input logic lvl, input int max, inout int c);
      while (pick(w) !== lvl && c < max)
      begin
         @(negedge mclk);
         c++;
      end
   endtask

   task automatic wait_state(input bcs_state_t st, input int max_sec, output int c);
      c = 0;
      while (seq_state !== st && c < max_sec * SEC)
      begin
         @(negedge mclk);
         c++;
      end
      check(seq_state === st, "state not reached in time");
   endtask

   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (rst === 1'b0 && ramp_clear === 1'b1)
         check(charge_en === 1'b0, "current on while measuring");
      if (cycles == LIMIT)
      begin
         error_cnt++;
         $display("MISMATCH at %0t: run did not finish", $time);
         end_sim();
      end
   end

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      check(seq_state === ST_FAULT && led_fault === 1'b1, "reset state");
      check(led_charge === 1'b0 && led_done === 1'b0 && charge_en === 1'b0, "reset outputs");
      rst = 1'b0;
      n = 0;
      wait_for(0, 1'b1, 2 * SEC, n);
      n = 0;
      @(negedge mclk);
      n++;
      wait_for(0, 1'b0, 2 * SEC, n);
      wait_for(0, 1'b1, 2 * SEC, n);
      check(n === SEC, "measurement spacing");
      check(seq_state === ST_FAULT, "filter still filling");
   endtask

   task automatic t_charge();
      wait_state(ST_INIT, 8, n);
      repeat (SEC) @(negedge mclk);
      check(led_charge === 1'b1 && led_fault === 1'b0, "init lamps");
      wait_state(ST_CHARGE, INIT_S + 2, n);
      check(n + SEC > (INIT_S - 1) * SEC, "init too short");
      repeat (20) @(negedge mclk);
      check(charge_en === 1'b1, "no current in charge");
      wait_state(ST_DONE, WD_S + 2, n);
      check(n > (WD_S - 1) * SEC, "steady pack ended early");
   endtask

   task automatic t_topup();
      n = 0;
      wait_for(1, 1'b1, (TOP_S + 2) * SEC, n);
      check(charge_en === 1'b1 && n > (TOP_S - 1) * SEC, "first pulse");
      check(led_done === 1'b1 && led_charge === 1'b0, "done lamps");
      len = 0;
      wait_for(1, 1'b0, 2 * SEC, len);
      check(len > SEC / 8 && len < SEC, "pulse length");
      n = len;
      wait_for(1, 1'b1, (TOP_S + 3) * SEC, n);
      check(n > (TOP_S + 1) * SEC - SEC / 2 && n < (TOP_S + 1) * SEC + SEC / 2, "pulse spacing");
   endtask

   task automatic t_remove();
      batt_period = 16'h012c;
      wait_state(ST_FAULT, 10, n);
      repeat (SEC) @(negedge mclk);
      check(led_fault === 1'b1 && led_done === 1'b0 && charge_en === 1'b0, "fault outputs");
   endtask

   task automatic t_delta();
      batt_period = 16'h0320;
      wait_state(ST_INIT, 6, n);
      check(n > SEC, "raw sample used");
      wait_state(ST_CHARGE, INIT_S + 2, n);
      repeat (2 * SEC) @(negedge mclk);
      check(seq_state === ST_CHARGE, "steady pack terminated");
      // Two percent longer period: voltage two percent below peak
      batt_period = 16'h0330;
      wait_state(ST_DONE, 7, n);
      check(n > 3 * SEC, "drop seen before filter settled");
   endtask

   initial
   begin
      repeat (12) @(negedge mclk);
      t_reset();
      t_charge();
      t_topup();
      t_remove();
      t_delta();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
